// >>> logic/nvs_core.v
/*
 * Serial nonvolatile SRAM core: SPI slave front end (modes 0 and 3), byte
 * array with burst read and write, and the save / restore sequencer with
 * the open-drain busy/request line.
 * Assumes clk is much faster than the serial clock, and that the supply
 * monitor and serial pins arrive asynchronously. The nonvolatile cells
 * are modelled as a second flip-flop array, copied whole in one cycle.
 */
// Operation
// - Write: opcode, three address bytes, one data byte, stored with no wait.
// - Burst write continues at next address, wrapping to zero after the last.
// - Read: opcode and three address bytes, then data shifts out immediately.
// - Burst read continues at next address while clocked, wrapping to zero.
// - Saves start on supply loss, on save command, or on a low line.
// - A save erases then programs the cells, blocking array access meanwhile.
// - During command or line saves and command restores, line is low and ready flag is one.
// - Supply-loss and line saves are skipped when nothing was written.
// - Command saves issued while the sequencer is idle run, written or not.
// - Supply loss with autosave enabled blocks access and saves conditionally.
// - Command save blocks access for the save time, then re-enables it.
// - External low on idle line starts a conditional save after a delay.
// - After a line save, access stays blocked for save time or while low.
// - The line is pulled low by an open-drain driver during any save.
// - After line or command saves, line is driven high briefly, then released.
// - Access stays blocked for a recovery interval after the line goes high.
// - Restore clears the array, copies the cells in, cells stay unchanged.
// - Supply rise starts an undisableable restore, blocked for the power-up time.
// - Disable and enable commands clear or set the volatile autosave enable.
// - Deselected: input ignored, output released; commands begin at select fall.
`timescale 1ns/1ps
`include "nvs_regs.vh"
module nvs_core (
	input  wire       clk,
	input  wire       sys_rst,
	input  wire       spi_sck,
	input  wire       spi_cs_n,
	input  wire       spi_si,
	output reg        spi_so,
	output reg        spi_so_oe,
	input  wire       busy_request_line_in,
	output reg        busy_request_line_out,
	output reg        busy_request_line_oe,
	input  wire       supply_ok,
	output reg        ready_status_busy,
	output reg        access_blocked,
	output reg        autosave_enable
);
	localparam DEPTH = 131072;

	// Sequencer states.
	localparam S_POWERUP = 3'd0;
	localparam S_IDLE    = 3'd1;
	localparam S_REQWAIT = 3'd2;
	localparam S_STORE   = 3'd3;
	localparam S_RECALL  = 3'd4;
	localparam S_HIGHDRV = 3'd5;
	localparam S_RECOVER = 3'd6;
	localparam S_DOWN    = 3'd7;

	// Serial front-end states.
	localparam F_OPCODE = 2'd0;
	localparam F_ADDR   = 2'd1;
	localparam F_DATA   = 2'd2;
	localparam F_IGNORE = 2'd3;

	reg [7:0] sram [0:DEPTH-1];
	reg [7:0] nvcell [0:DEPTH-1];

	wire sck_s;
	wire cs_act_s;
	wire si_s;
	wire line_s;
	wire supply_s;

	nvs_sync u_sck (.clk(clk), .sys_rst(sys_rst), .din(spi_sck), .dout(sck_s));
	// Select is synchronised inverted: its reset level then matches an idle pin, so reset makes no false fall.
	nvs_sync u_cs (.clk(clk), .sys_rst(sys_rst), .din(~spi_cs_n), .dout(cs_act_s));
	nvs_sync u_si (.clk(clk), .sys_rst(sys_rst), .din(spi_si), .dout(si_s));
	nvs_sync u_line (.clk(clk), .sys_rst(sys_rst), .din(busy_request_line_in), .dout(line_s));
	nvs_sync u_sup (.clk(clk), .sys_rst(sys_rst), .din(supply_ok), .dout(supply_s));
	wire cs_n_s = ~cs_act_s;

	reg        sck_d;
	reg        cs_n_d;
	reg        supply_d;
	reg        armed;
	reg [1:0]  fstate;
	reg [7:0]  shreg;
	reg [2:0]  bitcnt;
	reg [1:0]  bytecnt;
	reg [16:0] addr;
	reg        is_read;
	reg [7:0]  obuf;
	reg        rd_active;
	reg        written;
	reg [2:0]  state;
	reg [13:0] timer;
	reg        cmd_store;
	reg        cmd_recall;
	reg        cmd_asdis;
	reg        cmd_asen;

	wire sck_rise = sck_s & ~sck_d;
	wire sck_fall = ~sck_s & sck_d;
	wire cs_fall  = ~cs_n_s & cs_n_d;
	wire selected = ~cs_n_s & armed;
	wire [7:0] byte_in = {shreg[6:0], si_s};
	wire byte_done = selected & sck_rise & (bitcnt == 3'd7);
	wire idle_ok = (state == S_IDLE);
	wire [16:0] addr_next = (addr == `NVS_LAST_ADDR) ? `NVS_ZERO_ADDR : addr + 17'h0_0001;

	// Serial front end.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sck_d      <= 1'b0;
			cs_n_d     <= 1'b1;
			armed      <= 1'b0;
			fstate     <= F_OPCODE;
			shreg      <= 8'h00;
			bitcnt     <= 3'd0;
			bytecnt    <= 2'd0;
			addr       <= `NVS_ZERO_ADDR;
			is_read    <= 1'b0;
			obuf       <= 8'h00;
			rd_active  <= 1'b0;
			spi_so     <= 1'b0;
			spi_so_oe  <= 1'b0;
			cmd_store  <= 1'b0;
			cmd_recall <= 1'b0;
			cmd_asdis  <= 1'b0;
			cmd_asen   <= 1'b0;
		end else begin
			sck_d      <= sck_s;
			cs_n_d     <= cs_n_s;
			cmd_store  <= 1'b0;
			cmd_recall <= 1'b0;
			cmd_asdis  <= 1'b0;
			cmd_asen   <= 1'b0;
			if (cs_fall) begin
				armed     <= 1'b1;
				fstate    <= F_OPCODE;
				bitcnt    <= 3'd0;
				bytecnt   <= 2'd0;
				rd_active <= 1'b0;
			end else if (cs_n_s) begin
				spi_so_oe <= 1'b0;
				rd_active <= 1'b0;
			end else if (selected) begin
				if (sck_rise) begin
					shreg  <= byte_in;
					bitcnt <= bitcnt + 3'd1;
				end
				if (byte_done) begin
					case (fstate)
						F_OPCODE: begin
							fstate  <= F_IGNORE;
							is_read <= (byte_in == `NVS_OP_READ);
							if (byte_in == `NVS_OP_READ || byte_in == `NVS_OP_WRITE) begin
								fstate <= access_blocked ? F_IGNORE : F_ADDR;
							end
							cmd_store  <= (byte_in == `NVS_OP_STORE) & idle_ok;
							cmd_recall <= (byte_in == `NVS_OP_RECALL) & idle_ok;
							cmd_asdis  <= (byte_in == `NVS_OP_AS_DISABLE);
							cmd_asen   <= (byte_in == `NVS_OP_AS_ENABLE);
						end
						F_ADDR: begin
							addr    <= {addr[8:0], byte_in};
							bytecnt <= bytecnt + 2'd1;
							if (bytecnt == 2'd2) begin
								fstate <= F_DATA;
								if (is_read) begin
									obuf      <= sram[{addr[8:0], byte_in}];
									rd_active <= 1'b1;
								end
							end
						end
						F_DATA: begin
							if (is_read) begin
								addr <= addr_next;
								obuf <= sram[addr_next];
							end else begin
								addr <= addr_next;
							end
						end
						default: begin
							fstate <= F_IGNORE;
						end
					endcase
				end
				if (rd_active && sck_fall && !access_blocked) begin
					spi_so    <= obuf[~bitcnt];
					spi_so_oe <= 1'b1;
				end
			end
		end
	end

	// Array writes and the save / restore copies share one process so the
	// array keeps a single driver.
	integer i;
	always @(posedge clk) begin
		if (!sys_rst) begin
			if (selected && byte_done && fstate == F_DATA && !is_read && !access_blocked) begin
				sram[addr] <= byte_in;
			end
			if (state == S_STORE && timer == 14'd1) begin
				for (i = 0; i < DEPTH; i = i + 1) begin
					nvcell[i] <= sram[i];
				end
			end
			if (state == S_RECALL && timer == 14'd1) begin
				for (i = 0; i < DEPTH; i = i + 1) begin
					sram[i] <= nvcell[i];
				end
			end
		end
	end

	wire write_event = selected & byte_done & (fstate == F_DATA) & ~is_read & ~access_blocked;
	wire copy_done = ((state == S_STORE) || (state == S_RECALL)) && (timer == 14'd1);
	wire line_low_ext = ~line_s & ~busy_request_line_oe;

	// Save / restore sequencer.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state                 <= S_POWERUP;
			timer                 <= 14'd0;
			written               <= 1'b0;
			supply_d              <= 1'b0;
			autosave_enable       <= 1'b1;
			busy_request_line_out <= 1'b0;
			busy_request_line_oe  <= 1'b0;
			ready_status_busy     <= 1'b0;
			access_blocked        <= 1'b1;
		end else begin
			supply_d <= supply_s;
			if (write_event) begin
				written <= 1'b1;
			end else if (copy_done) begin
				written <= 1'b0;
			end
			if (cmd_asdis) begin
				autosave_enable <= 1'b0;
			end else if (cmd_asen) begin
				autosave_enable <= 1'b1;
			end
			if (timer != 14'd0) begin
				timer <= timer - 14'd1;
			end
			case (state)
				S_POWERUP: begin
					access_blocked        <= 1'b1;
					busy_request_line_out <= 1'b0;
					busy_request_line_oe  <= 1'b1;
					if (supply_s && !supply_d) begin
						state <= S_RECALL;
						timer <= `NVS_FA_CYC;
					end
				end
				S_IDLE: begin
					busy_request_line_oe <= 1'b0;
					ready_status_busy    <= 1'b0;
					access_blocked       <= 1'b0;
					if (!supply_s) begin
						access_blocked <= 1'b1;
						if (autosave_enable && written) begin
							state                <= S_STORE;
							timer                <= `NVS_STORE_CYC;
							busy_request_line_oe <= 1'b1;
						end else begin
							state <= S_DOWN;
						end
					end else if (cmd_store) begin
						state                <= S_STORE;
						timer                <= `NVS_STORE_CYC;
						access_blocked       <= 1'b1;
						ready_status_busy    <= 1'b1;
						busy_request_line_oe <= 1'b1;
					end else if (cmd_recall) begin
						state                <= S_RECALL;
						timer                <= `NVS_RECALL_CYC;
						access_blocked       <= 1'b1;
						ready_status_busy    <= 1'b1;
						busy_request_line_oe <= 1'b1;
					end else if (line_low_ext) begin
						state <= S_REQWAIT;
						timer <= `NVS_DELAY_CYC;
					end
				end
				S_REQWAIT: begin
					if (!line_low_ext) begin
						state <= S_IDLE;
					end else if (timer == 14'd1) begin
						if (written) begin
							state                <= S_STORE;
							timer                <= `NVS_STORE_CYC;
							access_blocked       <= 1'b1;
							ready_status_busy    <= 1'b1;
							busy_request_line_oe <= 1'b1;
						end else begin
							state          <= S_RECOVER;
							timer          <= `NVS_LZHSB_CYC;
							access_blocked <= 1'b1;
						end
					end
				end
				S_STORE: begin
					busy_request_line_out <= 1'b0;
					if (timer == 14'd1) begin
						if (!supply_s) begin
							state <= S_DOWN;
						end else begin
							state                 <= S_HIGHDRV;
							timer                 <= `NVS_HHHD_CYC;
							busy_request_line_out <= 1'b1;
						end
					end
				end
				S_RECALL: begin
					if (timer == 14'd1) begin
						state                 <= S_RECOVER;
						timer                 <= `NVS_LZHSB_CYC;
						busy_request_line_oe  <= 1'b0;
						ready_status_busy     <= 1'b0;
					end
				end
				S_HIGHDRV: begin
					if (timer == 14'd1) begin
						state                 <= S_RECOVER;
						timer                 <= `NVS_LZHSB_CYC;
						busy_request_line_oe  <= 1'b0;
						busy_request_line_out <= 1'b0;
						ready_status_busy     <= 1'b0;
					end
				end
				S_RECOVER: begin
					// Holding the line low from outside extends the block.
					if (line_low_ext) begin
						timer <= `NVS_LZHSB_CYC;
					end else if (timer <= 14'd1) begin
						state <= S_IDLE;
					end
				end
				S_DOWN: begin
					access_blocked       <= 1'b1;
					busy_request_line_oe <= 1'b0;
					ready_status_busy    <= 1'b0;
					if (supply_s) begin
						state <= S_RECALL;
						timer <= `NVS_FA_CYC;
						busy_request_line_oe  <= 1'b1;
						busy_request_line_out <= 1'b0;
					end
				end
				default: begin
					state <= S_POWERUP;
				end
			endcase
		end
	end
endmodule

// >>> logic/nvs_regs.vh
/*
 * Constants of the serial nonvolatile SRAM core: opcodes, address width,
 * timing figures and the cycle counts derived from them at 125 MHz.
 * Assumes the includer is plain Verilog-2005.
 */
`ifndef NVS_REGS_VH
`define NVS_REGS_VH

`define NVS_CLK_MHZ        125
`define NVS_ADDR_W         17
`define NVS_LAST_ADDR      17'h1_FFFF
`define NVS_ZERO_ADDR      17'h0_0000

`define NVS_OP_WRITE       8'h02
`define NVS_OP_READ        8'h03
`define NVS_OP_STORE       8'h3C
`define NVS_OP_RECALL      8'h60
`define NVS_OP_AS_DISABLE  8'h19
`define NVS_OP_AS_ENABLE   8'h59

`define NVS_T_STORE_US     8
`define NVS_T_RECALL_US    2
`define NVS_T_FA_US        20
`define NVS_T_DELAY_NS     64
`define NVS_HIGH_DRIVE_INTERVAL_NS      40
`define NVS_POST_BUSY_RECOVERY_INTERVAL_NS     48

// Cycle counts of the times above at 125 MHz, sized to the sequencer's timer so no bits are dropped.
`define NVS_STORE_CYC      14'h03E8
`define NVS_RECALL_CYC     14'h00FA
`define NVS_FA_CYC         14'h09C4
`define NVS_DELAY_CYC      14'h0008
`define NVS_HHHD_CYC       14'h0005
`define NVS_LZHSB_CYC      14'h0006

`endif

// >>> logic/nvs_sync.v
/*
 * Two-flip-flop synchroniser for one level from outside the clk domain.
 * Assumes the input changes slowly compared with clk.
 */
`timescale 1ns/1ps
module nvs_sync (
	input  wire clk,
	input  wire sys_rst,
	input  wire din,
	output reg  dout
);
	reg meta;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// >>> test/nvs_core_monitor.sv
/* Checker for nvs_core: busy line, access blocking and serial output.
   Assumes it is bound to nvs_core and sees only that module's ports. */
`timescale 1ns/1ps
module nvs_core_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	input wire logic spi_so,
	input wire logic spi_so_oe,
	input wire logic busy_request_line_in,
	input wire logic busy_request_line_out,
	input wire logic busy_request_line_oe,
	input wire logic supply_ok,
	input wire logic ready_status_busy,
	input wire logic access_blocked,
	input wire logic autosave_enable
);
	logic        low_drv;
	logic [10:0] low_cnt;
	assign low_drv = busy_request_line_oe && !busy_request_line_out;
	// Length of the current low drive, so that store and restore times can be checked when it ends.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			low_cnt <= 11'h000;
		else if (low_drv)
			low_cnt <= low_cnt + 11'h001;
		else
			low_cnt <= 11'h000;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_low_blk; low_drv |-> access_blocked; endproperty
	property p_rdy_blk; ready_status_busy |-> access_blocked; endproperty
	property p_hi_drive;
		$rose(busy_request_line_oe && busy_request_line_out) |->
			(busy_request_line_oe && busy_request_line_out)[*5] ##1 !busy_request_line_oe;
	endproperty
	property p_recov; $fell(busy_request_line_oe) |-> access_blocked[*5]; endproperty
	property p_so_rel; spi_cs_n[*5] |-> !spi_so_oe; endproperty
	property p_busy_len;
		$fell(low_drv) && $past(ready_status_busy) |-> low_cnt inside {[249:251], [999:1001]};
	endproperty
	property p_so_blk; $rose(spi_so_oe) |-> !access_blocked; endproperty
	property p_supply; !supply_ok[*4] |-> access_blocked; endproperty
	a_low_blk: assert property (p_low_blk) else $error("line low while access open");
	a_rdy_blk: assert property (p_rdy_blk) else $error("ready flag while access open");
	a_hi_drive: assert property (p_hi_drive) else $error("high drive length wrong");
	a_recov: assert property (p_recov) else $error("recovery interval too short");
	a_so_rel: assert property (p_so_rel) else $error("output driven while deselected");
	a_busy_len: assert property (p_busy_len) else $error("busy time wrong");
	a_so_blk: assert property (p_so_blk) else $error("read served while blocked");
	a_supply: assert property (p_supply) else $error("access open without supply");
	c_busy: cover property ($rose(ready_status_busy));
	c_hi: cover property ($rose(busy_request_line_oe && busy_request_line_out));
	c_read: cover property ($rose(spi_so_oe));
endmodule
bind nvs_core nvs_core_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
	.spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .busy_request_line_in(busy_request_line_in),
	.busy_request_line_out(busy_request_line_out), .busy_request_line_oe(busy_request_line_oe),
	.supply_ok(supply_ok), .ready_status_busy(ready_status_busy), .access_blocked(access_blocked),
	.autosave_enable(autosave_enable));

// >>> test/nvs_core_tb.sv
/* Self-checking bench for nvs_core with a byte model of both arrays.
   Assumes nvs_spi_master as the serial master and a pulled-up busy line. */
`timescale 1ns/1ps
`include "nvs_regs.vh"
module nvs_core_tb;
	logic      clk = 1'h0;
	logic      sys_rst = 1'h1;
	logic      supply_ok = 1'h0;
	logic      ext_low = 1'h0;
	wire logic sck, cs_n, si, so, so_oe, l_out, l_oe, rdy, blk, ase;
	wire logic line = !((l_oe && !l_out) || ext_low);
	// A released output shows the inverse of its last bit, so data taken while released cannot pass.
	wire logic so_pin = so_oe ? so : ~so;
	int        err_count = 0;
	int        comparisons = 0;
	logic [7:0] mem [int];
	logic [7:0] nv [int];
	always #4 clk = ~clk;
	nvs_core uut (.clk(clk), .sys_rst(sys_rst), .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so),
		.spi_so_oe(so_oe), .busy_request_line_in(line), .busy_request_line_out(l_out),
		.busy_request_line_oe(l_oe), .supply_ok(supply_ok), .ready_status_busy(rdy),
		.access_blocked(blk), .autosave_enable(ase));
	nvs_spi_master mst (.clk(clk), .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so_pin));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (blk !== 1'h0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n == 5000) begin
			chk_bit(1'h1, 1'h0, "access never released");
			summarize();
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		logic [7:0] rx;
		mst.sel();
		mst.xfer(op, rx);
		mst.desel();
	endtask
	task automatic hdr(input logic [7:0] op, input logic [16:0] a);
		logic [7:0]  rx;
		logic [23:0] w;
		w = {7'h00, a};
		mst.sel();
		mst.xfer(op, rx);
		for (int i = 2; i >= 0; i--)
			mst.xfer(w[i*8 +: 8], rx);
	endtask
	// The 17-bit address wraps from the last location to zero by itself.
	task automatic wr(input logic [16:0] a, input int n);
		logic [7:0] d;
		logic [7:0] rx;
		hdr(`NVS_OP_WRITE, a);
		repeat (n) begin
			d = 8'($urandom);
			mst.xfer(d, rx);
			mem[a] = d;
			a = a + 17'h0_0001;
		end
		mst.desel();
	endtask
	task automatic rd(input logic [16:0] a, input int n);
		logic [7:0] rx;
		hdr(`NVS_OP_READ, a);
		repeat (n) begin
			mst.xfer(8'h00, rx);
			chk(rx, mem[a], "read data");
			a = a + 17'h0_0001;
		end
		mst.desel();
	endtask
	initial begin
		void'($urandom(53477));
		repeat (20) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (10) @(posedge clk);
		chk_bit(blk, 1'h1, "blocked before supply");
		supply_ok <= 1'h1;
		wait_idle();
		chk_bit(ase, 1'h1, "autosave default");
		$display("power-up done");
		wr(`NVS_LAST_ADDR, 3);
		rd(`NVS_LAST_ADDR, 3);
		$display("burst done");
		repeat (2) begin
			cmd(`NVS_OP_STORE);
			chk_bit(rdy, 1'h1, "ready in store");
			chk_bit(line, 1'h0, "line in store");
			wait_idle();
		end
		nv = mem;
		$display("command save done");
		@(posedge clk) ext_low <= 1'h1;
		repeat (20) @(posedge clk);
		chk_bit(l_oe, 1'h0, "clean line save");
		chk_bit(blk, 1'h1, "blocked while low");
		ext_low <= 1'h0;
		wait_idle();
		wr(17'h0_0100, 1);
		@(posedge clk) ext_low <= 1'h1;
		repeat (20) @(posedge clk);
		chk_bit(l_oe, 1'h1, "line save runs");
		ext_low <= 1'h0;
		wait_idle();
		nv = mem;
		$display("line save done");
		wr(17'h0_0100, 1);
		cmd(`NVS_OP_RECALL);
		chk_bit(rdy, 1'h1, "ready in restore");
		wait_idle();
		mem = nv;
		rd(17'h0_0100, 1);
		$display("restore done");
		cmd(`NVS_OP_AS_DISABLE);
		chk_bit(ase, 1'h0, "autosave off");
		cmd(`NVS_OP_AS_ENABLE);
		chk_bit(ase, 1'h1, "autosave on");
		$display("autosave control done");
		wr(17'h0_0200, 2);
		@(posedge clk) supply_ok <= 1'h0;
		repeat (20) @(posedge clk);
		chk_bit(line, 1'h0, "supply loss save");
		nv = mem;
		repeat (1200) @(posedge clk);
		supply_ok <= 1'h1;
		repeat (2) @(posedge clk);
		wait_idle();
		mem = nv;
		rd(17'h0_0200, 2);
		$display("power cycle done");
		summarize();
	end
endmodule

// >>> test/nvs_spi_master.sv
/* Mode 0 serial master model with a 125 ns serial clock.
   Assumes the caller sequences select, bytes and deselect through its tasks. */
`timescale 1ns/1ps
module nvs_spi_master (
	input  wire logic clk,
	output logic      spi_sck,
	output logic      spi_cs_n,
	output logic      spi_si,
	input  wire logic spi_so
);
	initial begin
		spi_sck = 1'h0;
		spi_cs_n = 1'h1;
		spi_si = 1'h0;
	end
	// Starting a quarter nanosecond off a clk edge keeps every later pin change off the sampling edges.
	task automatic sel();
		@(posedge clk);
		#100.25 spi_cs_n = 1'h0;
		#100;
	endtask
	// The idle data line flips so a stale bit can never pass for a real one.
	task automatic desel();
		#100 spi_cs_n = 1'h1;
		spi_si = ~spi_si;
		#200;
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_si = tx[i];
			#62.5 spi_sck = 1'h1;
			rx[i] = spi_so;
			#62.5 spi_sck = 1'h0;
		end
	endtask
endmodule
